//--- verilog/rsef_pkg.sv
package rsef_pkg;

  // Register byte offsets on the bus
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_FLAG = 8'h04;
  localparam logic [7:0] OFS_IE = 8'h08;
  localparam logic [7:0] OFS_COUNT = 8'h0c;
  localparam logic [7:0] OFS_STATE = 8'h10;
  localparam logic [1:0] TABLE_REGION = 2'b01;

  // Sizes
  localparam int NUM_FLAGS = 7;
  localparam int FE_WIDTH = 8;
  localparam int TABLE_DEPTH = 16;
  localparam int SYNC_WIDTH = FE_WIDTH + 4;

  // Flag positions
  localparam int FLG_FRONT_END = 0;
  localparam int FLG_STOP = 1;
  localparam int FLG_START = 2;
  localparam int FLG_CNT1 = 3;
  localparam int FLG_CNT2 = 4;
  localparam int FLG_BIT6 = 5;
  localparam int FLG_BIT7 = 6;

  // Control register field positions
  localparam int CTL_SCAN_EN = 0;
  localparam int CTL_CNT1_UP = 1;
  localparam int CTL_CNT1_DN = 2;
  localparam int CTL_CNT2_DN = 3;
  localparam int CTL_CNT_RST = 4;
  localparam int CTL_FE_SEL = 8;
  localparam int CTL_IS1 = 12;
  localparam int CTL_IS2 = 14;

  // State byte bit positions
  localparam int Q_PAIR_LOW = 0;
  localparam int Q_BIT_ONE = 1;
  localparam int Q_BIT_TWO = 2;
  localparam int Q_PAIR_HIGH = 3;
  localparam int Q_BIT_SIX = 6;
  localparam int Q_BIT_SEVEN = 7;

  // Synchroniser lane positions
  localparam int SYN_PAIR_LOW = FE_WIDTH;
  localparam int SYN_PAIR_HIGH = FE_WIDTH + 1;
  localparam int SYN_STOP = FE_WIDTH + 2;
  localparam int SYN_START = FE_WIDTH + 3;

  // Reset values
  localparam logic [7:0] STATE_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [NUM_FLAGS-1:0] IE_RESET = 7'h00;

  // Quadrature decoding table, index {previous pair, current pair}
  localparam logic [7:0] TABLE_RESET [TABLE_DEPTH] = '{
    8'h00, 8'h03, 8'h0c, 8'h49,
    8'h00, 8'h01, 8'h48, 8'h09,
    8'h00, 8'h41, 8'h08, 8'h09,
    8'h40, 8'h01, 8'h08, 8'h09
  };

  // Interval masks: count modulo 4, 16, 64, 256
  localparam logic [7:0] INTERVAL_MASK [4] = '{8'h03, 8'h0f, 8'h3f, 8'hff};

  typedef struct packed {
    logic [1:0] is2;
    logic [1:0] is1;
    logic [2:0] fe_sel;
    logic cnt_rst;
    logic cnt2_dn;
    logic cnt1_dn;
    logic cnt1_up;
    logic scan_en;
  } rsef_ctrl_t;

  localparam rsef_ctrl_t CTRL_RESET = '0;

  typedef struct packed {
    logic [7:0] cnt2;
    logic [7:0] cnt1;
  } rsef_counts_t;

  typedef enum logic [3:0] {
    BUS_IDLE = 4'b0001,
    BUS_WRITE = 4'b0010,
    BUS_RWAIT = 4'b0100,
    BUS_RDATA = 4'b1000
  } rsef_bus_t;

endpackage

//--- verilog/rsef_flag.sv
`timescale 1ns/1ps
module rsef_flag
  import rsef_pkg::*;
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // Events
  input wire logic set_in,
  input wire logic clear_in,
  // State
  output logic flag_out
);

  logic flag_q;

  // Set beats a clear in the same cycle
  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
      flag_q <= 1'b0;
    else if (set_in)
      flag_q <= 1'b1;
    else if (clear_in)
      flag_q <= 1'b0;
  end

  assign flag_out = flag_q;

endmodule

//--- verilog/rsef_interval.sv
`timescale 1ns/1ps
module rsef_interval
  import rsef_pkg::*;
#(
  parameter int WIDTH = 8
)
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // Counter view
  input wire logic clear_in,
  input wire logic [WIDTH-1:0] count_in,
  input wire logic [1:0] sel_in,
  // One-cycle crossing pulse
  output logic hit_out
);

  logic [WIDTH-1:0] last_q;
  logic on_boundary;

  assign on_boundary = (count_in & INTERVAL_MASK[sel_in]) == '0;
  // Same boundary again after a wobble does not count
  assign hit_out = on_boundary && (count_in != last_q) && !clear_in;

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in || clear_in)
      last_q <= '0;
    else if (hit_out)
      last_q <= count_in;
  end

endmodule

//--- verilog/rsef_top.sv
// Chosen here: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
// How it works
// - Seven event flags share one interrupt line, each with its own enable.
// - Interrupt is high only for set, enabled flags while global enable is high.
// - Hardware never clears a flag; only a software write does.
// - Flag 0 sets when the selected front-end output turns active.
// - Flag 1 sets on each rising edge of the sequencer stop signal.
// - Flag 2 sets when the sequencer starts a new sequence.
// - Flag 3 sets when counter one reaches its selected count interval.
// - Flag 4 sets when counter two reaches its selected count interval.
// - Flag 5 sets on entry into a state whose byte has bit six set.
// - Flag 6 sets on entry into a state whose byte has bit seven set.
// - Interval flags use hysteresis; wobbling over a boundary sets them once.
// - Direction comes from previous and current sensor pairs; 00 goes to 01 or 10.
// - Full rotations count leaving 00: 003h counts up, 00Ch counts down.
// - Both sensor bits changing at once is an error entry with bit six set.
// - Counter one counts up on bit one entry and down on bit two entry.
module rsef_top
  import rsef_pkg::*;
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // AHB-Lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // Sensor front end and sequencer, asynchronous
  input wire logic [FE_WIDTH-1:0] front_end_output_in,
  input wire logic sequencer_stop_signal_in,
  input wire logic sequence_start_in,
  input wire logic sensor_pair_low_in,
  input wire logic sensor_pair_high_in,
  // Processor side
  input wire logic global_irq_enable_in,
  output logic irq_out
);

  rsef_bus_t bus_q;
  rsef_bus_t bus_d;
  logic [7:0] addr_q;
  logic [31:0] hrdata_q;
  rsef_ctrl_t ctrl_q;
  logic [NUM_FLAGS-1:0] ie_q;
  logic [NUM_FLAGS-1:0] flags;
  logic [NUM_FLAGS-1:0] flag_set;
  logic [NUM_FLAGS-1:0] flag_clear;
  logic [7:0] table_q [TABLE_DEPTH];
  logic [SYNC_WIDTH-1:0] sync1_q;
  logic [SYNC_WIDTH-1:0] sync2_q;
  logic [SYNC_WIDTH-1:0] prev_q;
  logic [7:0] state_q;
  logic started_q;
  logic step_q;
  rsef_counts_t counts_q;
  logic bus_req;
  logic wr_en;
  logic rd_load;
  logic table_hit;
  logic [3:0] table_idx;
  logic [3:0] next_idx;
  logic cnt_clear;
  logic scan_off;
  logic stop_rise;
  logic stop_fall;
  logic start_rise;
  logic fe_rise;
  logic [31:0] rd_mux;
  logic cnt1_hit;
  logic cnt2_hit;

  // Bus front end: writes take no wait, reads one wait state
  assign bus_req = hsel_in && htrans_in[1] && hready_in;
  assign wr_en = (bus_q == BUS_WRITE);
  assign rd_load = (bus_q == BUS_RWAIT);
  assign hreadyout_out = (bus_q != BUS_RWAIT);
  assign hresp_out = 1'b0;
  assign hrdata_out = hrdata_q;
  assign table_hit = (addr_q[7:6] == TABLE_REGION);
  assign table_idx = addr_q[5:2];

  always_comb
  begin
    bus_d = BUS_IDLE;
    unique case (bus_q)
      BUS_RWAIT:
        bus_d = BUS_RDATA;
      BUS_IDLE, BUS_WRITE, BUS_RDATA:
      begin
        if (bus_req)
          bus_d = hwrite_in ? BUS_WRITE : BUS_RWAIT;
      end
      default:
        bus_d = BUS_IDLE;
    endcase
  end

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      bus_q <= BUS_IDLE;
      addr_q <= '0;
    end
    else
    begin
      bus_q <= bus_d;
      if (bus_q != BUS_RWAIT && bus_req)
        addr_q <= {haddr_in[7:2], 2'b00};
    end
  end

  // Read multiplexer
  always_comb
  begin
    rd_mux = '0;
    if (table_hit)
      rd_mux = {24'h000000, table_q[table_idx]};
    else
    begin
      unique case (addr_q)
        OFS_CTRL:
          rd_mux = {16'h0000, ctrl_q.is2, ctrl_q.is1, 1'b0, ctrl_q.fe_sel,
                    3'b000, ctrl_q.cnt_rst, ctrl_q.cnt2_dn, ctrl_q.cnt1_dn,
                    ctrl_q.cnt1_up, ctrl_q.scan_en};
        OFS_FLAG:
          rd_mux = {25'h0000000, flags};
        OFS_IE:
          rd_mux = {25'h0000000, ie_q};
        OFS_COUNT:
          rd_mux = {16'h0000, counts_q};
        OFS_STATE:
          rd_mux = {23'h000000, started_q, state_q};
        default:
          rd_mux = '0;
      endcase
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
      hrdata_q <= '0;
    else if (rd_load)
      hrdata_q <= rd_mux;
  end

  // Control and enable registers
  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      ctrl_q <= CTRL_RESET;
      ie_q <= IE_RESET;
    end
    else if (wr_en && addr_q == OFS_CTRL)
    begin
      ctrl_q.scan_en <= hwdata_in[CTL_SCAN_EN];
      ctrl_q.cnt1_up <= hwdata_in[CTL_CNT1_UP];
      ctrl_q.cnt1_dn <= hwdata_in[CTL_CNT1_DN];
      ctrl_q.cnt2_dn <= hwdata_in[CTL_CNT2_DN];
      ctrl_q.cnt_rst <= hwdata_in[CTL_CNT_RST];
      ctrl_q.fe_sel <= hwdata_in[CTL_FE_SEL +: 3];
      ctrl_q.is1 <= hwdata_in[CTL_IS1 +: 2];
      ctrl_q.is2 <= hwdata_in[CTL_IS2 +: 2];
    end
    else if (wr_en && addr_q == OFS_IE)
      ie_q <= hwdata_in[NUM_FLAGS-1:0];
  end

  // State table storage, loaded with the quadrature decoder
  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
      table_q <= TABLE_RESET;
    else if (wr_en && table_hit)
      table_q[table_idx] <= hwdata_in[7:0];
  end

  // Two-stage synchronisers, then a history stage for edges
  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q <= '0;
    end
    else
    begin
      sync1_q <= {sequence_start_in, sequencer_stop_signal_in, sensor_pair_high_in,
                  sensor_pair_low_in, front_end_output_in};
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  assign scan_off = !ctrl_q.scan_en;
  assign stop_rise = sync2_q[SYN_STOP] && !prev_q[SYN_STOP];
  assign stop_fall = !sync2_q[SYN_STOP] && prev_q[SYN_STOP];
  assign start_rise = sync2_q[SYN_START] && !prev_q[SYN_START];
  assign fe_rise = sync2_q[ctrl_q.fe_sel] && !prev_q[ctrl_q.fe_sel];

  // Next index: previous pair from the state byte, current pair from sensors
  always_comb
  begin
    next_idx = {2'b00, sync2_q[SYN_PAIR_HIGH], sync2_q[SYN_PAIR_LOW]};
    if (started_q)
      next_idx[3:2] = {state_q[Q_PAIR_HIGH], state_q[Q_PAIR_LOW]};
  end

  // State machine steps on the falling edge of the stop signal
  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in || scan_off)
    begin
      state_q <= STATE_RESET;
      started_q <= 1'b0;
      step_q <= 1'b0;
    end
    else
    begin
      step_q <= stop_fall;
      if (stop_fall)
      begin
        state_q <= table_q[next_idx];
        started_q <= 1'b1;
      end
    end
  end

  // Rotation counters react to the byte just entered
  assign cnt_clear = rd_load && addr_q == OFS_COUNT && ctrl_q.cnt_rst;

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in || scan_off || cnt_clear)
      counts_q <= '{cnt2: COUNT_RESET, cnt1: COUNT_RESET};
    else if (step_q)
    begin
      if (ctrl_q.cnt1_up && state_q[Q_BIT_ONE]
          && !(ctrl_q.cnt1_dn && state_q[Q_BIT_TWO]))
        counts_q.cnt1 <= counts_q.cnt1 + 8'h01;
      else if (ctrl_q.cnt1_dn && state_q[Q_BIT_TWO]
               && !(ctrl_q.cnt1_up && state_q[Q_BIT_ONE]))
        counts_q.cnt1 <= counts_q.cnt1 - 8'h01;
      if (ctrl_q.cnt2_dn && state_q[Q_BIT_TWO])
        counts_q.cnt2 <= counts_q.cnt2 - 8'h01;
    end
  end

  rsef_interval #(
    .WIDTH(8)
  ) u_cnt1_interval (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .clear_in(scan_off || cnt_clear),
    .count_in(counts_q.cnt1),
    .sel_in(ctrl_q.is1),
    .hit_out(cnt1_hit)
  );

  rsef_interval #(
    .WIDTH(8)
  ) u_cnt2_interval (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .clear_in(scan_off || cnt_clear),
    .count_in(counts_q.cnt2),
    .sel_in(ctrl_q.is2),
    .hit_out(cnt2_hit)
  );

  // Event sources for the flags
  always_comb
  begin
    flag_set = '0;
    flag_set[FLG_FRONT_END] = ctrl_q.scan_en && fe_rise;
    flag_set[FLG_STOP] = ctrl_q.scan_en && stop_rise;
    flag_set[FLG_START] = ctrl_q.scan_en && start_rise;
    flag_set[FLG_CNT1] = cnt1_hit;
    flag_set[FLG_CNT2] = cnt2_hit;
    flag_set[FLG_BIT6] = step_q && state_q[Q_BIT_SIX];
    flag_set[FLG_BIT7] = step_q && state_q[Q_BIT_SEVEN];
  end

  // Writing a one clears that flag
  assign flag_clear = (wr_en && addr_q == OFS_FLAG) ? hwdata_in[NUM_FLAGS-1:0] : '0;

  for (genvar i = 0; i < NUM_FLAGS; i++)
  begin : g_flag
    rsef_flag u_flag (
      .clock_in(clock_in),
      .rst_n_in(rst_n_in),
      .set_in(flag_set[i]),
      .clear_in(flag_clear[i]),
      .flag_out(flags[i])
    );
  end

  // One shared request line
  assign irq_out = global_irq_enable_in && |(flags & ie_q);

endmodule

//--- testbench/rsef_checker.sv
`timescale 1ns/1ps
module rsef_checker (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // Bus
  input wire logic hsel_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic hready_in,
  input wire logic [31:0] hrdata_out,
  input wire logic hreadyout_out,
  input wire logic hresp_out,
  // Interrupt
  input wire logic global_irq_enable_in,
  input wire logic irq_out
);
  logic take;
  logic wr_q;
  logic rd_q;
  assign take = hsel_in && htrans_in[1] && hready_in;
  // Data phase of the transfer taken at the last edge
  always_ff @(posedge clock_in)
  begin
    wr_q <= rst_n_in && take && hwrite_in;
    rd_q <= rst_n_in && take && !hwrite_in;
  end
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  AST_RST_IDLE: assert property (disable iff (1'b0)
    !rst_n_in |=> hreadyout_out && !irq_out && hrdata_out == 32'h0)
    else $error("outputs not idle in reset");
  AST_OKAY_ONLY: assert property (hresp_out == 1'b0)
    else $error("response not okay");
  AST_RD_WAIT: assert property (take && !hwrite_in |=> !hreadyout_out ##1 hreadyout_out)
    else $error("read wait state wrong");
  AST_WR_NOWAIT: assert property (take && hwrite_in |=> hreadyout_out)
    else $error("write stalled");
  AST_IDLE_READY: assert property (!hreadyout_out |-> rd_q)
    else $error("ready low outside read");
  AST_RDATA_HOLD: assert property (!rd_q |=> $stable(hrdata_out))
    else $error("read data moved");
  AST_GIE_GATE: assert property (!global_irq_enable_in |-> !irq_out)
    else $error("irq without global enable");
  AST_IRQ_HOLD: assert property (irq_out && !wr_q && !(take && hwrite_in)
    |=> irq_out || !global_irq_enable_in)
    else $error("irq dropped without write");
  AST_IRQ_FALL: assert property ($fell(irq_out) && global_irq_enable_in
    && $past(global_irq_enable_in) |-> $past(wr_q))
    else $error("irq fell without write");
  cover property (take && !hwrite_in);
  cover property ($rose(irq_out));
  cover property ($fell(irq_out) && global_irq_enable_in);
endmodule

bind rsef_top rsef_checker u_chk (.clock_in, .rst_n_in, .hsel_in, .htrans_in, .hwrite_in,
  .hready_in, .hrdata_out, .hreadyout_out, .hresp_out, .global_irq_enable_in, .irq_out);

//--- testbench/rotation_scan_event_flags_bench.sv
`timescale 1ns/1ps
module rotation_scan_event_flags_bench;
  import rsef_pkg::*;
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic hsel_in = 1'b0;
  logic [31:0] haddr_in = 32'h0;
  logic [1:0] htrans_in = 2'b00;
  logic hwrite_in = 1'b0;
  logic [2:0] hsize_in = 3'b010;
  logic [31:0] hwdata_in = 32'h0;
  logic hready_in;
  logic [31:0] hrdata_out;
  logic hreadyout_out;
  logic hresp_out;
  logic [7:0] front_end_output_in = 8'h00;
  logic sequencer_stop_signal_in = 1'b0;
  logic sequence_start_in = 1'b0;
  logic sensor_pair_low_in = 1'b0;
  logic sensor_pair_high_in = 1'b0;
  logic global_irq_enable_in = 1'b0;
  logic irq_out;
  int num_errors = 0;
  int num_checks = 0;
  integer seed = 32'hfc068349;
  logic [31:0] rd;
  logic [7:0] tbl [16] = '{8'h00, 8'h03, 8'h0c, 8'h49, 8'h00, 8'h01, 8'h48, 8'h09,
    8'h00, 8'h41, 8'h08, 8'h09, 8'h40, 8'h01, 8'h08, 8'h09};
  logic [7:0] regs [6] = '{OFS_CTRL, OFS_FLAG, OFS_IE, OFS_COUNT, OFS_STATE, 8'h20};
  int walk [21] = '{0, 1, 0, 1, 0, 1, 0, 1, 0, 2, 0, 1, 0, 3, 0, 1, 2, 3, 0, 2, 1};
  int st = 0;
  int cnt1 = 0;
  int cnt2 = 0;
  int lt1 = 0;
  int lt2 = 0;
  int m1 = 4;
  int m2 = 4;
  int flg = 0;
  int started = 0;
  assign hready_in = hreadyout_out;
  always #4 clock_in = ~clock_in;
  rsef_top dut (.clock_in, .rst_n_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in,
    .hsize_in, .hwdata_in, .hready_in, .hrdata_out, .hreadyout_out, .hresp_out,
    .front_end_output_in, .sequencer_stop_signal_in, .sequence_start_in,
    .sensor_pair_low_in, .sensor_pair_high_in, .global_irq_enable_in, .irq_out);

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel_in <= 1'b1;
    haddr_in <= {24'h0, a};
    htrans_in <= 2'b10;
    hwrite_in <= w;
    do @(posedge clock_in); while (hreadyout_out !== 1'b1);
    hsel_in <= 1'b0;
    htrans_in <= 2'b00;
    hwdata_in <= d;
    do @(posedge clock_in); while (hreadyout_out !== 1'b1);
    rd = hrdata_out;
  endtask

  // Interval crossing with hysteresis memory
  function automatic int hit(input int c, input int m, inout int last);
    hit = (c % m == 0 && c != last);
    if (hit)
      last = c;
  endfunction

  // One sequence: start rise, stop pulse, state step on stop fall
  task automatic step(input int p);
    int idx;
    int q;
    bus(OFS_FLAG, 1'b1, 32'h7f);
    flg = 0;
    sensor_pair_low_in <= p[0];
    sensor_pair_high_in <= p[1];
    sequence_start_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    sequencer_stop_signal_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    sequence_start_in <= 1'b0;
    sequencer_stop_signal_in <= 1'b0;
    repeat (12) @(posedge clock_in);
    idx = started ? {st[3], st[0], p[1], p[0]} : p[1:0];
    q = tbl[idx];
    st = q;
    started = 1;
    flg = 6;
    if (q[1] && !q[2])
      cnt1 = (cnt1 + 1) % 256;
    if (q[2] && !q[1])
      cnt1 = (cnt1 + 255) % 256;
    if (q[2])
      cnt2 = (cnt2 + 255) % 256;
    flg |= (q[6] << 5) | (q[7] << 6) | (hit(cnt1, m1, lt1) << 3) | (hit(cnt2, m2, lt2) << 4);
    bus(OFS_FLAG, 1'b0, 32'h0);
    chk("flags", rd, flg);
    chk("irq", irq_out, 1);
    bus(OFS_STATE, 1'b0, 32'h0);
    chk("state", rd, 32'h100 | st);
    bus(OFS_COUNT, 1'b0, 32'h0);
    chk("count", rd, (cnt2 << 8) | cnt1);
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    int sel;
    int other;
    repeat (12) @(posedge clock_in);
    rst_n_in <= 1'b1;
    foreach (regs[i])
    begin
      bus(regs[i], 1'b0, 32'h0);
      chk("reset reg", rd, 0);
    end
    for (int i = 0; i < 16; i++)
    begin
      bus(8'h40 + 8'(4 * i), 1'b0, 32'h0);
      chk("table", rd, tbl[i]);
    end
    sel = $unsigned($random(seed)) % 8;
    other = $random(seed) & ~(1 << sel) & 8'hff;
    bus(OFS_CTRL, 1'b1, 32'h0f | (sel << CTL_FE_SEL));
    bus(OFS_IE, 1'b1, 32'h7f);
    global_irq_enable_in <= 1'b1;
    front_end_output_in <= other[7:0];
    repeat (6) @(posedge clock_in);
    bus(OFS_FLAG, 1'b0, 32'h0);
    chk("fe idle", rd, 0);
    front_end_output_in <= other[7:0] | 8'(1 << sel);
    repeat (6) @(posedge clock_in);
    front_end_output_in <= 8'h00;
    bus(OFS_FLAG, 1'b0, 32'h0);
    chk("fe flag", rd, 1);
    chk("irq on", irq_out, 1);
    global_irq_enable_in <= 1'b0;
    @(posedge clock_in);
    chk("irq gie", irq_out, 0);
    global_irq_enable_in <= 1'b1;
    bus(OFS_IE, 1'b1, 32'h7e);
    @(posedge clock_in);
    chk("irq mask", irq_out, 0);
    bus(OFS_FLAG, 1'b0, 32'h0);
    chk("flag kept", rd, 1);
    bus(OFS_FLAG, 1'b1, 32'h1);
    bus(OFS_FLAG, 1'b0, 32'h0);
    chk("flag clr", rd, 0);
    // Clear write lands on the same edge as the front-end set
    front_end_output_in <= 8'(1 << sel);
    @(posedge clock_in);
    bus(OFS_FLAG, 1'b1, 32'h1);
    front_end_output_in <= 8'h00;
    bus(OFS_FLAG, 1'b0, 32'h0);
    chk("set wins", rd, 1);
    bus(OFS_IE, 1'b1, 32'h7f);
    tbl[0] = 8'h80;
    bus(8'h40, 1'b1, 32'h80);
    foreach (walk[i])
      step(walk[i]);
    bus(OFS_CTRL, 1'b1, 32'h0f | (sel << CTL_FE_SEL) | (1 << CTL_IS1) | (2 << CTL_IS2));
    m1 = 16;
    m2 = 64;
    repeat (12)
      step($unsigned($random(seed)) % 4);
    repeat (20) @(posedge clock_in);
    bus(OFS_FLAG, 1'b0, 32'h0);
    chk("flag stays", rd, flg);
    bus(OFS_CTRL, 1'b1, 32'h1f);
    bus(OFS_COUNT, 1'b0, 32'h0);
    chk("count rd", rd, (cnt2 << 8) | cnt1);
    bus(OFS_COUNT, 1'b0, 32'h0);
    chk("count rst", rd, 0);
    bus(OFS_CTRL, 1'b1, 32'h0);
    bus(OFS_STATE, 1'b0, 32'h0);
    chk("state off", rd, 0);
    summarize();
  end

  // Watchdog
  initial
  begin
    repeat (20000) @(posedge clock_in);
    num_errors++;
    summarize();
  end
endmodule
